// File: verilog/smk_host.sv
/*
 * host controller end: ahb-lite register slave that issues control words.
 * assumes a single ahb-lite master on hclk; device answers on the link.
 */
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module smk_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    smk_link_if.host link
);
    typedef enum logic [1:0] {H_IDLE, H_KEY2, H_KWAIT} smk_hst_type;

    smk_hst_type st_r, st_nxt;
    logic wr_r, wr_nxt;
    logic [7:0] wa_r, wa_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic cv_r, cv_nxt;
    logic [15:0] cw_r, cw_nxt;
    logic [15:0] k2_r, k2_nxt;
    logic kv_r, kv_nxt;
    logic [1:0] ks_r, ks_nxt;
    logic [15:0] kd_r, kd_nxt;
    logic kwok_r, kwok_nxt;
    logic ref_r, ref_nxt;
    logic sub_hit;

    always_comb begin
        sub_hit = (hwdata[15:0] == smk_pkg::SUB_SEAL) || (hwdata[15:0] == smk_pkg::SUB_BOOT) ||
                  (hwdata[15:0] == smk_pkg::SUB_BOOT_EXIT);
        wr_nxt = hsel && hready && htrans == smk_pkg::HTRANS_NONSEQ && hwrite;
        wa_nxt = haddr;
        rd_nxt = 32'h0000_0000;
        if (haddr == smk_pkg::REG_STATUS) begin
            rd_nxt[smk_pkg::ST_BUSY] = (st_r != H_IDLE);
            rd_nxt[smk_pkg::ST_SEALED] = link.sealed_flag;
            rd_nxt[smk_pkg::ST_FULL_LOCKED] = link.full_access_locked_flag;
            rd_nxt[smk_pkg::ST_BOOT] = link.boot_flag;
            rd_nxt[smk_pkg::ST_KW_OK] = kwok_r;
            rd_nxt[smk_pkg::ST_REFUSED] = ref_r;
            rd_nxt[smk_pkg::ST_KEY_LSB +: 16] = link.kr_data;
        end
        st_nxt = st_r;
        cv_nxt = 1'b0;
        cw_nxt = cw_r;
        k2_nxt = k2_r;
        kv_nxt = 1'b0;
        ks_nxt = ks_r;
        kd_nxt = kd_r;
        kwok_nxt = kwok_r;
        ref_nxt = ref_r;
        case (st_r)
            H_IDLE: begin
                if (wr_r && wa_r == smk_pkg::REG_CMD) begin
                    cv_nxt = 1'b1;
                    cw_nxt = hwdata[15:0];
                end else if (wr_r && wa_r == smk_pkg::REG_UNLOCK) begin
                    cv_nxt = 1'b1;
                    cw_nxt = {hwdata[7:0], hwdata[15:8]};
                    k2_nxt = {hwdata[23:16], hwdata[31:24]};
                    st_nxt = H_KEY2;
                end else if (wr_r && wa_r == smk_pkg::REG_KEYW) begin
                    ks_nxt = hwdata[smk_pkg::KEYW_SEL_LSB +: 2];
                    ref_nxt = sub_hit;
                    if (!sub_hit) begin
                        kv_nxt = 1'b1;
                        kd_nxt = hwdata[15:0];
                        st_nxt = H_KWAIT;
                    end
                end
            end
            H_KEY2: begin
                cv_nxt = 1'b1;
                cw_nxt = k2_r;
                st_nxt = H_IDLE;
            end
            H_KWAIT: begin
                if (link.kw_done) begin
                    kwok_nxt = link.kw_ok;
                    st_nxt = H_IDLE;
                end
            end
            default: begin
                st_nxt = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= H_IDLE;
            wr_r <= 1'b0;
            wa_r <= 8'h00;
            rd_r <= 32'h0000_0000;
            cv_r <= 1'b0;
            cw_r <= 16'h0000;
            k2_r <= 16'h0000;
            kv_r <= 1'b0;
            ks_r <= 2'h0;
            kd_r <= 16'h0000;
            kwok_r <= 1'b0;
            ref_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            wr_r <= wr_nxt;
            wa_r <= wa_nxt;
            rd_r <= rd_nxt;
            cv_r <= cv_nxt;
            cw_r <= cw_nxt;
            k2_r <= k2_nxt;
            kv_r <= kv_nxt;
            ks_r <= ks_nxt;
            kd_r <= kd_nxt;
            kwok_r <= kwok_nxt;
            ref_r <= ref_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rd_r;
    assign link.cmd_valid = cv_r;
    assign link.cmd_word = cw_r;
    assign link.kw_valid = kv_r;
    assign link.kw_sel = ks_r;
    assign link.kw_data = kd_r;
    assign link.kr_sel = ks_r;
endmodule : smk_host
`default_nettype wire

// File: verilog/smk_pkg.sv
/*
 * shared constants and types of the security mode key unlock link.
 * assumes one clock hclk at 25 mhz and an active-low asynchronous reset.
 */
`default_nettype none
package smk_pkg;
    localparam int WORD_W = 16;
    localparam int KEY_SEL_W = 2;
    // key store slots
    localparam logic [1:0] KEY_UNSEAL0 = 2'h0;
    localparam logic [1:0] KEY_UNSEAL1 = 2'h1;
    localparam logic [1:0] KEY_FULL0 = 2'h2;
    localparam logic [1:0] KEY_FULL1 = 2'h3;
    // stored key reset values, arbitrary
    localparam logic [15:0] KEY_UNSEAL0_RST = 16'h5a11;
    localparam logic [15:0] KEY_UNSEAL1_RST = 16'h6b22;
    localparam logic [15:0] KEY_FULL0_RST = 16'h7c33;
    localparam logic [15:0] KEY_FULL1_RST = 16'h8d44;
    // subcommand codes
    localparam logic [15:0] SUB_SEAL = 16'h0020;
    localparam logic [15:0] SUB_BOOT = 16'h0f00;
    localparam logic [15:0] SUB_BOOT_EXIT = 16'h0f01;
    // host register offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_UNLOCK = 8'h04;
    localparam logic [7:0] REG_KEYW = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    // host field positions
    localparam int KEYW_SEL_LSB = 16;
    localparam int ST_BUSY = 0;
    localparam int ST_SEALED = 1;
    localparam int ST_FULL_LOCKED = 2;
    localparam int ST_BOOT = 3;
    localparam int ST_KW_OK = 4;
    localparam int ST_REFUSED = 5;
    localparam int ST_KEY_LSB = 16;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {SMK_SEALED, SMK_UNSEALED, SMK_FULL, SMK_BOOT} smk_mode_type;
endpackage : smk_pkg
`default_nettype wire

// File: verilog/smk_link_if.sv
/*
 * link between host controller and secured device.
 * assumes both ends on hclk; host drives commands, device drives status.
 */
`timescale 1ns/10ps
`default_nettype none
interface smk_link_if;
    logic cmd_valid;
    logic [15:0] cmd_word;
    logic kw_valid;
    logic [1:0] kw_sel;
    logic [15:0] kw_data;
    logic [1:0] kr_sel;
    logic kw_done;
    logic kw_ok;
    logic [15:0] kr_data;
    logic sealed_flag;
    logic full_access_locked_flag;
    logic boot_flag;
    modport dev (input cmd_valid, cmd_word, kw_valid, kw_sel, kw_data, kr_sel,
                 output kw_done, kw_ok, kr_data, sealed_flag, full_access_locked_flag, boot_flag);
    modport host (output cmd_valid, cmd_word, kw_valid, kw_sel, kw_data, kr_sel,
                  input kw_done, kw_ok, kr_data, sealed_flag, full_access_locked_flag, boot_flag);
endinterface : smk_link_if
`default_nettype wire

// File: verilog/smk_device.sv
/*
 * secured device end: key compare, mode state and key store.
 * assumes commands one word per cycle from the host, synchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
module smk_device (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    smk_link_if.dev link,
    output logic [1:0] mode,
    output logic boot_loader_mode
);
    typedef enum logic [1:0] {PEND_NONE, PEND_UNSEAL, PEND_FULL} smk_pend_type;

    smk_pkg::smk_mode_type mode_r, mode_nxt;
    smk_pend_type pend_r, pend_nxt;
    logic [15:0] key_r [4];
    logic [15:0] key_nxt [4];
    logic kw_done_r, kw_done_nxt;
    logic kw_ok_r, kw_ok_nxt;
    logic [15:0] kr_data_r, kr_data_nxt;
    logic sealed_r, sealed_nxt;
    logic full_lock_r, full_lock_nxt;
    logic boot_r, boot_nxt;

    // byte swap of a stored word
    function automatic logic [15:0] swap16(input logic [15:0] w);
        swap16 = {w[7:0], w[15:8]};
    endfunction : swap16

    always_comb begin
        mode_nxt = mode_r;
        pend_nxt = pend_r;
        if (link.cmd_valid) begin
            pend_nxt = PEND_NONE;
            case (pend_r)
                PEND_UNSEAL: begin
                    if (link.cmd_word == swap16(key_r[smk_pkg::KEY_UNSEAL1])) begin
                        mode_nxt = smk_pkg::SMK_UNSEALED;
                    end
                end
                PEND_FULL: begin
                    if (link.cmd_word == swap16(key_r[smk_pkg::KEY_FULL1])) begin
                        mode_nxt = smk_pkg::SMK_FULL;
                    end
                end
                PEND_NONE: begin
                    if (mode_r == smk_pkg::SMK_SEALED &&
                        link.cmd_word == swap16(key_r[smk_pkg::KEY_UNSEAL0])) begin
                        pend_nxt = PEND_UNSEAL;
                    end else if (mode_r == smk_pkg::SMK_UNSEALED &&
                                 link.cmd_word == swap16(key_r[smk_pkg::KEY_FULL0])) begin
                        pend_nxt = PEND_FULL;
                    end else if (link.cmd_word == smk_pkg::SUB_SEAL && mode_r != smk_pkg::SMK_BOOT) begin
                        mode_nxt = smk_pkg::SMK_SEALED;
                    end else if (link.cmd_word == smk_pkg::SUB_BOOT && mode_r == smk_pkg::SMK_FULL) begin
                        mode_nxt = smk_pkg::SMK_BOOT;
                    end else if (link.cmd_word == smk_pkg::SUB_BOOT_EXIT && mode_r == smk_pkg::SMK_BOOT) begin
                        mode_nxt = smk_pkg::SMK_FULL;
                    end
                end
                default: begin
                    pend_nxt = PEND_NONE;
                end
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            key_nxt[i] = key_r[i];
        end
        kw_done_nxt = link.kw_valid;
        kw_ok_nxt = 1'b0;
        if (link.kw_valid) begin
            if (mode_r == smk_pkg::SMK_FULL) begin
                key_nxt[link.kw_sel] = link.kw_data;
                kw_ok_nxt = 1'b1;
            end
        end
        kr_data_nxt = key_r[link.kr_sel];
        sealed_nxt = (mode_nxt == smk_pkg::SMK_SEALED);
        full_lock_nxt = !(mode_nxt == smk_pkg::SMK_FULL || mode_nxt == smk_pkg::SMK_BOOT);
        boot_nxt = (mode_nxt == smk_pkg::SMK_BOOT);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= smk_pkg::SMK_SEALED;
            pend_r <= PEND_NONE;
            kw_done_r <= 1'b0;
            kw_ok_r <= 1'b0;
            kr_data_r <= 16'h0000;
            sealed_r <= 1'b1;
            full_lock_r <= 1'b1;
            boot_r <= 1'b0;
        end else if (ce) begin
            mode_r <= mode_nxt;
            pend_r <= pend_nxt;
            kw_done_r <= kw_done_nxt;
            kw_ok_r <= kw_ok_nxt;
            kr_data_r <= kr_data_nxt;
            sealed_r <= sealed_nxt;
            full_lock_r <= full_lock_nxt;
            boot_r <= boot_nxt;
        end
    end

    // key store, reset stands in for nonvolatile defaults
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_r[0] <= smk_pkg::KEY_UNSEAL0_RST;
            key_r[1] <= smk_pkg::KEY_UNSEAL1_RST;
            key_r[2] <= smk_pkg::KEY_FULL0_RST;
            key_r[3] <= smk_pkg::KEY_FULL1_RST;
        end else if (ce) begin
            for (int i = 0; i < 4; i++) begin
                key_r[i] <= key_nxt[i];
            end
        end
    end

    assign link.kw_done = kw_done_r;
    assign link.kw_ok = kw_ok_r;
    assign link.kr_data = kr_data_r;
    assign link.sealed_flag = sealed_r;
    assign link.full_access_locked_flag = full_lock_r;
    assign link.boot_flag = boot_r;
    assign mode = mode_r;
    assign boot_loader_mode = boot_r;
endmodule : smk_device
`default_nettype wire

// File: test/smk_assertions.sv
/*
 * checker of the key unlock link.
 * assumes link signals on hclk, instantiated beside the interface.
 */
`timescale 1ns/10ps
`default_nettype none
module smk_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic kw_valid,
    input wire logic [1:0] kw_sel,
    input wire logic [15:0] kw_data,
    input wire logic [1:0] kr_sel,
    input wire logic kw_done,
    input wire logic kw_ok,
    input wire logic [15:0] kr_data,
    input wire logic sealed_flag,
    input wire logic full_access_locked_flag,
    input wire logic boot_flag
);
    logic [15:0] key_r [4];
    logic [15:0] key_nxt [4];
    logic full;
    assign full = !full_access_locked_flag && !boot_flag;
    // shadow of the key store
    always_comb begin
        key_nxt = key_r;
        if (kw_valid && full) begin
            key_nxt[kw_sel] = kw_data;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_r <= '{smk_pkg::KEY_UNSEAL0_RST, smk_pkg::KEY_UNSEAL1_RST,
                       smk_pkg::KEY_FULL0_RST, smk_pkg::KEY_FULL1_RST};
        end else begin
            key_r <= key_nxt;
        end
    end
    function automatic logic [15:0] sw(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction : sw
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence unseal_s;
        cmd_valid && sealed_flag && cmd_word == sw(key_r[0]) ##1 cmd_valid && cmd_word == sw(key_r[1]);
    endsequence
    sequence full_s;
        cmd_valid && !sealed_flag && !full && !boot_flag && cmd_word == sw(key_r[2])
        ##1 cmd_valid && cmd_word == sw(key_r[3]);
    endsequence
    sequence bad_s;
        cmd_valid && sealed_flag && cmd_word == sw(key_r[0]) ##1 cmd_valid && cmd_word != sw(key_r[1]);
    endsequence
    a_kw_done_next: assert property (kw_valid |=> kw_done) else $error("key write not answered");
    a_kw_ok_full: assert property (kw_valid |=> kw_ok == $past(full)) else $error("key write outcome wrong");
    a_sealed_stays: assert property (sealed_flag && !cmd_valid |=> sealed_flag)
        else $error("sealed flag lost");
    a_unseal_pair: assert property (unseal_s |=> !sealed_flag && full_access_locked_flag)
        else $error("unseal missed");
    a_full_pair: assert property (full_s |=> !full_access_locked_flag) else $error("full access missed");
    a_bad_second: assert property (bad_s |=> sealed_flag) else $error("wrong second key unsealed");
    a_boot_from_full: assert property ($rose(boot_flag) |-> $past(full)) else $error("boot not from full");
    a_key_readback: assert property ($past(hresetn) && !$past(kw_valid) && !$past(kw_valid, 2)
        |-> kr_data == $past(key_r[kr_sel])) else $error("stored key readback wrong");
endmodule : smk_assertions
`default_nettype wire

// File: test/security_mode_key_unlock_tb.sv
/*
 * testbench: both link ends joined, driven over ahb-lite.
 * assumes package, interface and both end modules compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module security_mode_key_unlock_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, boot_loader_mode;
    logic [7:0] haddr;
    logic [1:0] htrans, mode;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    logic [15:0] last_cmd;
    int n_mismatch, check_count;
    smk_link_if lk ();
    smk_host smk_host_i (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout(hready), .hrdata, .hresp, .link(lk.host));
    smk_device smk_device_i (.hclk, .hresetn, .ce(1'b1), .link(lk.dev), .mode, .boot_loader_mode);
    smk_assertions smk_assertions_i (.hclk, .hresetn, .cmd_valid(lk.cmd_valid), .cmd_word(lk.cmd_word),
        .kw_valid(lk.kw_valid), .kw_sel(lk.kw_sel), .kw_data(lk.kw_data), .kr_sel(lk.kr_sel),
        .kw_done(lk.kw_done), .kw_ok(lk.kw_ok), .kr_data(lk.kr_data), .sealed_flag(lk.sealed_flag),
        .full_access_locked_flag(lk.full_access_locked_flag), .boot_flag(lk.boot_flag));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (lk.cmd_valid === 1'b1) begin
            last_cmd <= lk.cmd_word;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic edge_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            n_mismatch++;
            final_report();
        end
    endtask : edge_ready
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= smk_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        edge_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_ready();
        q = hrdata;
    endtask : ahb
    task automatic idle();
        int n;
        n = 0;
        do begin
            ahb(smk_pkg::REG_STATUS, 1'b0, 32'h0);
            n++;
        end while ((q[smk_pkg::ST_BUSY] !== 1'b0 || n < 2) && n < 20);
        if (q[smk_pkg::ST_BUSY] !== 1'b0) begin
            n_mismatch++;
            final_report();
        end
    endtask : idle
    task automatic st_is(input logic [5:0] m, input logic [5:0] v);
        ahb(smk_pkg::REG_STATUS, 1'b0, 32'h0);
        check({26'h0, q[5:0] & m}, {26'h0, v});
    endtask : st_is
    task automatic cmd(input logic [7:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d);
        idle();
    endtask : cmd
    task automatic t_reset();
        st_is(6'h0f, 6'h06);
        check(32'(mode), 32'(smk_pkg::SMK_SEALED));
        ahb(8'h10, 1'b1, 32'hffff_ffff);
        ahb(8'h10, 1'b0, 32'h0);
        check(q, 32'h0);
        check({31'h0, hresp}, 32'h0);
    endtask : t_reset
    task automatic t_sealed();
        cmd(smk_pkg::REG_UNLOCK, {smk_pkg::KEY_FULL1_RST, smk_pkg::KEY_FULL0_RST});
        st_is(6'h0f, 6'h06);
        cmd(smk_pkg::REG_UNLOCK, {16'h0000, smk_pkg::KEY_UNSEAL0_RST});
        st_is(6'h0f, 6'h06);
        cmd(smk_pkg::REG_KEYW, 32'h0001_beef);
        st_is(6'h1f, 6'h06);
        check({16'h0, q[31:16]}, {16'h0, smk_pkg::KEY_UNSEAL1_RST});
        cmd(smk_pkg::REG_CMD, {16'h0, smk_pkg::SUB_BOOT});
        st_is(6'h0f, 6'h06);
    endtask : t_sealed
    task automatic t_unseal();
        cmd(smk_pkg::REG_UNLOCK, {smk_pkg::KEY_UNSEAL1_RST, smk_pkg::KEY_UNSEAL0_RST});
        st_is(6'h0f, 6'h04);
        check(32'(mode), 32'(smk_pkg::SMK_UNSEALED));
        check({16'h0, last_cmd}, {16'h0, smk_pkg::KEY_UNSEAL1_RST[7:0], smk_pkg::KEY_UNSEAL1_RST[15:8]});
        cmd(smk_pkg::REG_UNLOCK, {smk_pkg::KEY_UNSEAL1_RST, smk_pkg::KEY_UNSEAL0_RST});
        st_is(6'h0f, 6'h04);
        cmd(smk_pkg::REG_CMD, {16'h0, smk_pkg::SUB_BOOT});
        st_is(6'h0f, 6'h04);
        cmd(smk_pkg::REG_KEYW, 32'h0000_1234);
        st_is(6'h10, 6'h00);
    endtask : t_unseal
    task automatic t_full();
        cmd(smk_pkg::REG_UNLOCK, {smk_pkg::KEY_FULL1_RST, smk_pkg::KEY_FULL0_RST});
        st_is(6'h0f, 6'h00);
        cmd(smk_pkg::REG_KEYW, 32'h0000_1234);
        st_is(6'h1f, 6'h10);
        check({16'h0, q[31:16]}, 32'h1234);
        cmd(smk_pkg::REG_KEYW, {16'h0001, smk_pkg::SUB_SEAL});
        st_is(6'h20, 6'h20);
        cmd(smk_pkg::REG_CMD, {16'h0, smk_pkg::SUB_BOOT});
        st_is(6'h0f, 6'h08);
        check({31'h0, boot_loader_mode}, 32'h1);
        cmd(smk_pkg::REG_CMD, {16'h0, smk_pkg::SUB_BOOT_EXIT});
        st_is(6'h0f, 6'h00);
        cmd(smk_pkg::REG_CMD, {16'h0, smk_pkg::SUB_SEAL});
        st_is(6'h0f, 6'h06);
        cmd(smk_pkg::REG_UNLOCK, {smk_pkg::KEY_UNSEAL1_RST, 16'h1234});
        st_is(6'h0f, 6'h04);
    endtask : t_full
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_sealed();
        t_unseal();
        t_full();
        final_report();
    end
endmodule : security_mode_key_unlock_tb
`default_nettype wire
